// file: core/atsc_pkg.sv
// Purpose: constants for the task file status and control block
// Assumes: 8-bit task file, ata register addresses on cs/da pins
// Notes:   register addresses follow the usual ata block layout
package atsc_pkg;
	// chip select / address selects, {cs1, cs0, da[2:0]}
	localparam logic [4:0] ADDR_DRIVE_HEAD  = 5'h0e;
	localparam logic [4:0] ADDR_STATUS_CMD  = 5'h0f;
	localparam logic [4:0] ADDR_ALT_CTRL    = 5'h16;
	localparam logic [4:0] ADDR_DRIVE_ADDR  = 5'h17;
	// status byte bits
	localparam int BIT_BUSY       = 7;
	localparam int BIT_READY      = 6;
	localparam int BIT_WFAULT     = 5;
	localparam int BIT_SEEK_DONE  = 4;
	localparam int BIT_DATA_REQ   = 3;
	localparam int BIT_CORRECTED  = 2;
	localparam int BIT_INDEX      = 1;
	localparam int BIT_ERROR      = 0;
	// control byte bits
	localparam int BIT_SOFT_RESET = 2;
	localparam int BIT_INT_DIS    = 1;
	// drive/head bits
	localparam int BIT_DRIVE_SEL  = 4;
	// reset values
	localparam logic [7:0] RST_DRIVE_HEAD = 8'ha0;
	localparam logic       RST_INT_DIS    = 1'h0;
	localparam logic [7:0] RST_STATUS       = 8'h50;
	localparam logic [7:0] STATUS_BUSY_ONLY = 8'h80;
	// soft reset holds busy this long
	localparam int SOFT_RESET_BIT_NS      = 400;
	localparam int CLK_NS       = 8;
	localparam int SOFT_RESET_BIT_CYCLES  = (SOFT_RESET_BIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int SOFT_RESET_BIT_CNT_W   = 7;
	typedef enum logic [3:0] {
		ATSC_IDLE  = 4'b0001,
		ATSC_BUSY  = 4'b0010,
		ATSC_DONE  = 4'b0100,
		ATSC_SOFT_RESET_BIT  = 4'b1000
	} atsc_state_e;
endpackage

// file: core/atsc_host_decode.sv
// Purpose: decode one host strobe into register access pulses
// Assumes: rd/wr strobes are single-cycle, synchronous to clk_sys
// Notes:   no drive selection here; the task file gates command writes with it
`timescale 1ns/1ps
module atsc_host_decode
	import atsc_pkg::*;
(
	input  wire logic       rd_stb,
	input  wire logic       wr_stb,
	input  wire logic [4:0] addr,
	output logic            rd_status,
	output logic            rd_alt,
	output logic            rd_drv_addr,
	output logic            wr_cmd,
	output logic            wr_ctrl,
	output logic            wr_dh
);
	always_comb begin
		rd_status   = rd_stb && addr == ADDR_STATUS_CMD;
		rd_alt      = rd_stb && addr == ADDR_ALT_CTRL;
		rd_drv_addr = rd_stb && addr == ADDR_DRIVE_ADDR;
		wr_cmd      = wr_stb && addr == ADDR_STATUS_CMD;
		wr_ctrl     = wr_stb && addr == ADDR_ALT_CTRL;
		wr_dh       = wr_stb && addr == ADDR_DRIVE_HEAD;
	end
endmodule

// file: core/atsc_irq_pin.sv
// Purpose: tri-state interrupt request pin driver
// Assumes: pending level comes from the main block
// Notes:   pin released (oe low) rather than driven when disabled
`timescale 1ns/1ps
module atsc_irq_pin
	import atsc_pkg::*;
(
	input  wire logic pending,
	input  wire logic int_dis,
	input  wire logic selected,
	input  wire logic mem_mode,
	output logic      irq_n_o,
	output logic      irq_oe
);
	logic enabled;
	always_comb begin
		// memory mode has no disable bit at all
		enabled = mem_mode || (selected && !int_dis);
		irq_oe  = enabled;
		irq_n_o = !(pending && enabled);
	end
endmodule

// file: core/atsc_task_file.sv
// Purpose: status, command, control and drive address registers
// Assumes: host strobes one cycle wide, synchronous to clk_sys
// Notes:   the media engine reports via the op_* event inputs;
//          a media command drops seek complete until it is found again
//          control byte fixed bits are taken as written, not policed
`timescale 1ns/1ps
module atsc_task_file
	import atsc_pkg::*;
#(
	parameter int SOFT_RESET_BIT_HOLD = SOFT_RESET_BIT_CYCLES
) (
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	// host side of the task file
	input  wire logic       rd_stb,
	input  wire logic       wr_stb,
	input  wire logic [4:0] addr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata,
	output logic      [7:0] rdata_oe,
	input  wire logic       mem_mode,
	input  wire logic       drive_is_slave,
	output logic            irq_n_o,
	output logic            irq_oe,
	// media engine side
	output logic            cmd_valid,
	output logic      [7:0] cmd_code,
	input  wire logic       op_done,
	input  wire logic       op_error,
	input  wire logic       op_wfault,
	input  wire logic       op_seek_found,
	input  wire logic       op_corrected,
	input  wire logic       op_data_ready,
	input  wire logic       media_cmd,
	output logic            cmd_refused,
	output logic            soft_reset
);
	////////////////////////////////////////////////////////////////////
	typedef struct packed {
		atsc_state_e            st;
		logic [7:0]             status;
		logic [7:0]             dh;
		logic                   int_dis;
		logic                   pending;
		logic                   err_hold;
		logic [SOFT_RESET_BIT_CNT_W-1:0]  cnt;
		logic                   cmd_valid;
		logic [7:0]             cmd_code;
		logic                   refused;
		logic [7:0]             rdata;
		logic [7:0]             rdata_oe;
	} atsc_regs_s;

	atsc_regs_s r_ff;
	atsc_regs_s nxt_r;

	logic rd_status;
	logic rd_alt;
	logic rd_drv_addr;
	logic wr_cmd;
	logic wr_ctrl;
	logic wr_dh;
	logic selected;

	atsc_host_decode u_dec (
		.rd_stb      (rd_stb),
		.wr_stb      (wr_stb),
		.addr        (addr),
		.rd_status   (rd_status),
		.rd_alt      (rd_alt),
		.rd_drv_addr (rd_drv_addr),
		.wr_cmd      (wr_cmd),
		.wr_ctrl     (wr_ctrl),
		.wr_dh       (wr_dh)
	);

	// drive selection from drive/head bit 4 against strap
	assign selected = drive_selected(r_ff.dh, drive_is_slave);

	atsc_irq_pin u_irq (
		.pending  (r_ff.pending),
		.int_dis  (r_ff.int_dis),
		.selected (selected),
		.mem_mode (mem_mode),
		.irq_n_o  (irq_n_o),
		.irq_oe   (irq_oe)
	);

	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] status_view(input logic [7:0] s);
		logic [7:0] v;
		v = s;
		v[BIT_INDEX] = 1'b0;
		// other bits undefined while busy; show them masked
		if (s[BIT_BUSY])
			v = STATUS_BUSY_ONLY;
		return v;
	endfunction

	function automatic logic [7:0] drive_addr_view(input logic [7:0] dh,
		input logic slave);
		logic [7:0] v;
		v = 8'h00;
		v[5:2] = ~dh[3:0];
		v[1] = !(slave && dh[BIT_DRIVE_SEL]);
		v[0] = !(!slave && !dh[BIT_DRIVE_SEL]);
		v[6] = 1'b1; // write gate unused, idles high
		return v;
	endfunction

	function automatic logic drive_selected(input logic [7:0] dh,
		input logic slave);
		return dh[BIT_DRIVE_SEL] == slave;
	endfunction

	////////////////////////////////////////////////////////////////////
	// media commands need both flags up, else they are turned away
	function automatic logic media_ready(input logic [7:0] s);
		return s[BIT_READY] && s[BIT_SEEK_DONE];
	endfunction

	function automatic logic soft_reset_bit_written(input logic wr,
		input logic [7:0] d);
		return wr && d[BIT_SOFT_RESET];
	endfunction

	// engine events set flags, data request follows its level; other clears happen at accept
	function automatic logic [7:0] merge_events(input logic [7:0] s,
		input logic wfault, input logic seek, input logic corrected_data_flag,
		input logic dready);
		logic [7:0] v;
		v = s;
		if (wfault)
			v[BIT_WFAULT] = 1'b1;
		if (seek)
			v[BIT_SEEK_DONE] = 1'b1;
		if (corrected_data_flag)
			v[BIT_CORRECTED] = 1'b1;
		v[BIT_DATA_REQ] = dready;
		v[BIT_INDEX] = 1'b0;
		return v;
	endfunction

	// fresh command: busy up, stale result flags dropped, but an
	// event landing in the same cycle still wins over the clear
	function automatic logic [7:0] accept_status(input logic [7:0] s,
		input logic media, input logic wfault, input logic seek,
		input logic corrected_data_flag);
		logic [7:0] v;
		v = s;
		v[BIT_BUSY]      = 1'b1;
		v[BIT_ERROR]     = 1'b0;
		v[BIT_WFAULT]    = wfault;
		v[BIT_CORRECTED] = corrected_data_flag;
		// a media command must locate its sector again
		if (media)
			v[BIT_SEEK_DONE] = seek;
		return v;
	endfunction

	// turned-away command: error shown at once
	function automatic logic [7:0] refuse_status(input logic [7:0] s);
		logic [7:0] v;
		v = s;
		v[BIT_ERROR] = 1'b1;
		return v;
	endfunction

	// end of an operation: busy drops with the result in place
	function automatic logic [7:0] finish_status(input logic [7:0] s,
		input logic err);
		logic [7:0] v;
		v = s;
		v[BIT_BUSY]  = 1'b0;
		v[BIT_ERROR] = err;
		return v;
	endfunction

	// soft reset entry: host-visible state goes back to start
	function automatic atsc_regs_s soft_reset_bit_entry(input atsc_regs_s r);
		atsc_regs_s v;
		v = r;
		v.st       = ATSC_SOFT_RESET_BIT;
		v.cnt      = SOFT_RESET_BIT_CNT_W'(SOFT_RESET_BIT_HOLD);
		v.status   = STATUS_BUSY_ONLY;
		v.pending  = 1'b0;
		v.err_hold = 1'b0;
		v.dh       = RST_DRIVE_HEAD;
		return v;
	endfunction

	// registered read byte for whichever register the host picked
	function automatic logic [7:0] read_byte(input logic st_rd,
		input logic da_rd, input logic [7:0] s, input logic [7:0] dh,
		input logic slave, input logic [7:0] held);
		logic [7:0] v;
		v = held;
		if (st_rd)
			v = status_view(s);
		if (da_rd)
			v = drive_addr_view(dh, slave);
		return v;
	endfunction

	function automatic logic [7:0] read_enables(input logic st_rd,
		input logic da_rd);
		logic [7:0] v;
		v = 8'h00;
		if (st_rd)
			v = 8'hff;
		if (da_rd)
			v = 8'h7f; // bit 7 left floating
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_r = r_ff;
		nxt_r.cmd_valid = 1'b0;
		nxt_r.refused = 1'b0;
		nxt_r.rdata_oe = 8'h00;
		// engine events set flags; data request follows its level
		nxt_r.status = merge_events(r_ff.status, op_wfault,
			op_seek_found, op_corrected, op_data_ready);

		// reads: primary clears the request, alternate does not
		nxt_r.rdata = read_byte(rd_status || rd_alt, rd_drv_addr,
			r_ff.status, r_ff.dh, drive_is_slave, r_ff.rdata);
		nxt_r.rdata_oe = read_enables(rd_status || rd_alt, rd_drv_addr);
		if (rd_status) begin
			nxt_r.pending  = 1'b0;
			nxt_r.err_hold = 1'b0;
		end
		if (wr_dh)
			nxt_r.dh = wdata;
		if (wr_ctrl)
			// only bits 2 and 1 matter; fixed bits not checked
			nxt_r.int_dis = wdata[BIT_INT_DIS];

		unique case (r_ff.st)
			ATSC_IDLE: begin
				if (wr_cmd && selected) begin
					// parameters already in the task file by host order
					if (media_cmd && !media_ready(r_ff.status)) begin
						nxt_r.refused = 1'b1;
						nxt_r.status = refuse_status(nxt_r.status);
						nxt_r.pending = 1'b1;
					end else begin
						nxt_r.cmd_valid = 1'b1;
						nxt_r.cmd_code  = wdata;
						nxt_r.status = accept_status(nxt_r.status,
							media_cmd, op_wfault, op_seek_found,
							op_corrected);
						nxt_r.pending = 1'b0;
						nxt_r.st = ATSC_BUSY;
					end
				end
			end
			ATSC_BUSY: begin
				nxt_r.status[BIT_BUSY] = 1'b1;
				if (op_done) begin
					nxt_r.status = finish_status(nxt_r.status, op_error);
					if (op_error)
						nxt_r.err_hold = 1'b1;
					nxt_r.st = ATSC_DONE;
				end
			end
			ATSC_DONE: begin
				// status landed last cycle, now raise request
				nxt_r.pending = 1'b1;
				nxt_r.st = ATSC_IDLE;
			end
			ATSC_SOFT_RESET_BIT: begin
				nxt_r.status[BIT_BUSY] = 1'b1;
				if (r_ff.cnt != '0)
					nxt_r.cnt = r_ff.cnt - 1'b1;
				// a control write with the bit set in this cycle keeps the device in reset
				else if (!soft_reset_bit_written(wr_ctrl, wdata)) begin
					nxt_r.status = RST_STATUS;
					nxt_r.st = ATSC_IDLE;
				end
			end
			default: nxt_r.st = ATSC_IDLE;
		endcase

		// ready frozen while an error waits to be seen
		if (r_ff.err_hold && nxt_r.st != ATSC_SOFT_RESET_BIT)
			nxt_r.status[BIT_READY] = r_ff.status[BIT_READY];

		// soft reset wins over everything else
		if (soft_reset_bit_written(wr_ctrl, wdata))
			nxt_r = soft_reset_bit_entry(nxt_r);
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			r_ff <= '{st: ATSC_IDLE,
				status: RST_STATUS,
				dh: RST_DRIVE_HEAD,
				int_dis: RST_INT_DIS,
				pending: 1'b0,
				err_hold: 1'b0,
				cnt: '0,
				cmd_valid: 1'b0,
				cmd_code: 8'h00,
				refused: 1'b0,
				rdata: 8'h00,
				rdata_oe: 8'h00};
		end else begin
			r_ff <= nxt_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	assign rdata       = r_ff.rdata;
	assign rdata_oe    = r_ff.rdata_oe;
	assign cmd_valid   = r_ff.cmd_valid;
	assign cmd_code    = r_ff.cmd_code;
	assign cmd_refused = r_ff.refused;
	assign soft_reset  = r_ff.st == ATSC_SOFT_RESET_BIT;
endmodule

// file: tb/atsc_task_file_properties.sv
// Purpose: port-level properties of the task file block
// Assumes: one clock domain, host strobes one cycle wide
// Notes:   drive/head copy kept here to predict the echo byte
`timescale 1ns/1ps
module atsc_chk
	import atsc_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       arst_n,
	input wire logic       rd_stb,
	input wire logic       wr_stb,
	input wire logic [4:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic [7:0] rdata_oe,
	input wire logic       drive_is_slave,
	input wire logic       irq_n_o,
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic       soft_reset
);
	logic [7:0] dh_ff;
	logic [7:0] nxt_dh;
	wire        st_rd = rd_stb && (addr == ADDR_STATUS_CMD
		|| addr == ADDR_ALT_CTRL);
	wire        da_rd = rd_stb && addr == ADDR_DRIVE_ADDR;
	wire        sel = dh_ff[BIT_DRIVE_SEL] == drive_is_slave;
	always_comb begin
		nxt_dh = (wr_stb && addr == ADDR_DRIVE_HEAD) ? wdata : dh_ff;
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dh_ff <= RST_DRIVE_HEAD;
		end else begin
			dh_ff <= nxt_dh;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	a_status_clr: assert property (rd_stb && addr == ADDR_STATUS_CMD
		|=> irq_n_o) else $error("irq held after status read");
	a_alt_keep: assert property (rd_stb && addr == ADDR_ALT_CTRL
		&& !wr_stb && !irq_n_o |=> !irq_n_o) else $error("alt read cleared");
	a_status_oe: assert property (st_rd |=> rdata_oe == 8'hff)
		else $error("status read not driven");
	a_index_zero: assert property (st_rd |=> !rdata[BIT_INDEX])
		else $error("index bit set");
	a_busy_mask: assert property (st_rd |=>
		(!rdata[BIT_BUSY] || rdata[6:0] == 7'h00)) else $error("busy view");
	a_echo_float: assert property (da_rd |=> rdata_oe == 8'h7f)
		else $error("echo bit 7 driven");
	a_head_inv: assert property (da_rd |=>
		rdata[5:2] == ~$past(dh_ff[3:0])) else $error("head echo wrong");
	a_drive_sel: assert property (da_rd && sel |=>
		rdata[1:0] == ($past(drive_is_slave) ? 2'h1 : 2'h2))
		else $error("drive select echo wrong");
	a_cmd_cause: assert property (cmd_valid |->
		$past(wr_stb && addr == ADDR_STATUS_CMD) && cmd_code == $past(wdata))
		else $error("command accept without write");
	a_soft_reset_bit_start: assert property (wr_stb && addr == ADDR_ALT_CTRL
		&& wdata[BIT_SOFT_RESET] && sel |=> soft_reset)
		else $error("soft reset not started");
endmodule
bind atsc_task_file atsc_chk atsc_chk_inst (.clk_sys, .arst_n, .rd_stb,
	.wr_stb, .addr, .wdata, .rdata, .rdata_oe, .drive_is_slave, .irq_n_o,
	.cmd_valid, .cmd_code, .soft_reset);

// file: tb/atsc_media_model.sv
// Purpose: media engine stand-in answering accepted commands
// Assumes: one command at a time
// Notes:   fixed latency keeps busy up long enough to be read
`timescale 1ns/1ps
module atsc_media_model #(
	parameter int DLY = 6
) (
	input  wire logic clk_sys,
	input  wire logic arst_n,
	input  wire logic cmd_valid,
	input  wire logic err_cfg,
	output logic      op_done,
	output logic      op_error
);
	logic [3:0] cnt_ff;
	// busy may only end with this done pulse
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff   <= 4'h0;
			op_done  <= 1'b0;
			op_error <= 1'b0;
		end else begin
			op_done  <= cnt_ff == 4'h1;
			op_error <= cnt_ff == 4'h1 && err_cfg;
			if (cmd_valid) begin
				cnt_ff <= 4'(DLY);
			end else if (cnt_ff != 4'h0) begin
				cnt_ff <= cnt_ff - 4'h1;
			end
		end
	end
endmodule

// file: tb/atsc_task_file_tb.sv
// Purpose: self-checking bench for the task file block
// Assumes: soft reset hold shortened to 3 cycles
// Notes:   echo rows first, then status, irq and reset cases
`timescale 1ns/1ps
module atsc_task_file_tb;
	import atsc_pkg::*;
	logic       clk_sys, arst_n, rd_stb, wr_stb, mem_mode, drive_is_slave;
	logic       op_wfault, op_seek_found, op_corrected, op_data_ready;
	logic       media_cmd, err_cfg, irq_n_o, irq_oe, cmd_valid, cmd_refused;
	logic       soft_reset, op_done, op_error;
	logic [4:0] addr;
	logic [7:0] wdata, rdata, rdata_oe, cmd_code, rd_q, oe_q;
	int         fail_count, cmp_count;
	// {strap, drive/head, expected echo with bit 7 masked}
	logic [16:0] rows [4] = '{{1'h0, 8'ha0, 8'h7e}, {1'h1, 8'hb3, 8'h71},
		{1'h0, 8'ha5, 8'h6a}, {1'h1, 8'hfa, 8'h55}};
	atsc_task_file #(.SOFT_RESET_BIT_HOLD(3)) atsc_task_file_inst (.clk_sys, .arst_n,
		.rd_stb, .wr_stb, .addr, .wdata, .rdata, .rdata_oe, .mem_mode,
		.drive_is_slave, .irq_n_o, .irq_oe, .cmd_valid, .cmd_code, .op_done,
		.op_error, .op_wfault, .op_seek_found, .op_corrected, .op_data_ready,
		.media_cmd, .cmd_refused, .soft_reset);
	atsc_media_model atsc_media_model_inst (.clk_sys, .arst_n, .cmd_valid,
		.err_cfg, .op_done, .op_error);
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wr_stb <= 1'b1;
		addr   <= a;
		wdata  <= d;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a);
		@(posedge clk_sys);
		rd_stb <= 1'b1;
		addr   <= a;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
		#1;
		rd_q = rdata;
		oe_q = rdata_oe;
	endtask
	// alt reads leave the interrupt alone while polling
	task automatic wait_idle;
		rd_q = 8'hff;
		repeat (64) if (rd_q[BIT_BUSY] !== 1'b0) rd(ADDR_ALT_CTRL);
	endtask
	task automatic pin(input logic exp);
		repeat (2) @(posedge clk_sys);
		#1;
		chk({7'h0, irq_oe}, {7'h0, exp});
	endtask
	initial begin
		repeat (5000) @(posedge clk_sys);
		fail_count++;
		stop_test();
	end
	initial begin
		{arst_n, rd_stb, wr_stb, mem_mode, drive_is_slave, err_cfg} = '0;
		{op_wfault, op_seek_found, op_corrected, op_data_ready} = '0;
		{addr, wdata} = '0;
		media_cmd = 1'b1;
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		// dh written while still selected, strap moved after
		foreach (rows[i]) begin
			wr(ADDR_DRIVE_HEAD, rows[i][15:8]);
			drive_is_slave <= rows[i][16];
			rd(ADDR_DRIVE_ADDR);
			chk(rd_q & 8'h7f, rows[i][7:0]);
			chk(oe_q, 8'h7f);
		end
		wr(ADDR_DRIVE_HEAD, RST_DRIVE_HEAD);
		drive_is_slave <= 1'b0;
		$display("echo rows done");
		rd(ADDR_STATUS_CMD);
		chk(rd_q, 8'h50);
		chk(oe_q, 8'hff);
		$display("reset status done");
		err_cfg <= 1'b1;
		wr(ADDR_STATUS_CMD, 8'h20);
		rd(ADDR_STATUS_CMD);
		chk(rd_q, 8'h80);
		wait_idle();
		chk(rd_q, 8'h41);
		@(posedge clk_sys);
		#1;
		chk({7'h0, irq_n_o}, 8'h00);
		rd(ADDR_STATUS_CMD);
		chk(rd_q, 8'h41);
		chk({7'h0, irq_n_o}, 8'h01);
		$display("error command done");
		wr(ADDR_STATUS_CMD, 8'h20);
		#1;
		chk({7'h0, cmd_refused}, 8'h01);
		rd(ADDR_STATUS_CMD);
		chk(rd_q, 8'h41);
		$display("refused command done");
		err_cfg <= 1'b0;
		media_cmd <= 1'b0;
		wr(ADDR_STATUS_CMD, 8'h30);
		{op_wfault, op_seek_found, op_corrected, op_data_ready} <= 4'hf;
		#1;
		chk({7'h0, cmd_valid}, 8'h01);
		chk(cmd_code, 8'h30);
		@(posedge clk_sys);
		{op_wfault, op_seek_found, op_corrected} <= 3'h0;
		wait_idle();
		chk(rd_q, 8'h7c);
		rd(ADDR_STATUS_CMD);
		op_data_ready <= 1'b0;
		$display("flag command done");
		wr(ADDR_ALT_CTRL, 8'h0a);
		pin(1'b0);
		mem_mode <= 1'b1;
		pin(1'b1);
		mem_mode <= 1'b0;
		wr(ADDR_ALT_CTRL, 8'h08);
		drive_is_slave <= 1'b1;
		pin(1'b0);
		drive_is_slave <= 1'b0;
		pin(1'b1);
		$display("irq pin done");
		wr(ADDR_ALT_CTRL, 8'h0c);
		#1;
		chk({7'h0, soft_reset}, 8'h01);
		rd(ADDR_STATUS_CMD);
		chk(rd_q, 8'h80);
		wr(ADDR_ALT_CTRL, 8'h08);
		wait_idle();
		chk(rd_q, 8'h50);
		chk({7'h0, soft_reset}, 8'h00);
		$display("soft reset done");
		stop_test();
	end
endmodule
